// ---- core/ipt_arb_if.sv ----
// carrier between controller and priority arbiter
interface ipt_arb_if #(
    parameter int N = 16
);
    logic [N-1:0] pend;
    logic [N*3-1:0] prio;
    logic valid;
    logic [$clog2(N)-1:0] idx;
    logic [2:0] level;
    modport ctrl(output pend, output prio, input valid, input idx,
                 input level);
    modport arb(input pend, input prio, output valid, output idx,
                output level);
endinterface

// ---- core/ipt_arbiter.sv ----
// priority tree picking the best pending user source
module ipt_arbiter #(
    parameter int N = 16
) (
    ipt_arb_if.arb bus
);
    always_comb begin
        bus.valid = 1'b0;
        bus.idx = '0;
        bus.level = 3'h0;
        // scan downward so that the lowest index wins a tie
        for (int i = N - 1; i >= 0; i--) begin
            if (bus.pend[i] && bus.prio[i*3 +: 3] != 3'h0 &&
                (!bus.valid || bus.prio[i*3 +: 3] >= bus.level)) begin
                bus.valid = 1'b1;
                bus.idx = ($clog2(N))'(i);
                bus.level = bus.prio[i*3 +: 3];
            end
        end
    end
endmodule

// ---- core/ipt_ctrl.sv ----
// interrupt priority and trap control with wishbone register slave
// Operation
// - each source owns a flag set by hardware, cleared by software write
// - a source with its enable clear never interrupts
// - each user source has a 3-bit priority, seven usable levels
// - vector number and new level latched into vector status register
// - flag, enable and priority bits follow vector order from vector 8
// - low three cpu level bits sit in status bits 7:5, writable
// - top level bit in core control bit 3, software cannot write it
// - low bits 111 block all user interrupts
// - top level bit set blocks all user interrupts
// - nesting disable makes low cpu level bits read-only
// - trap control bit 15 is nesting disable, resets to 0
// - core control bit 15 selects variable exception latency
// - top level bit reads 1 exactly when level exceeds 7
// - bits 10, 9, 8 enable overflow and catastrophic overflow traps
// - bits 14 to 11 record overflow and catastrophic overflow causes
// - bit 4 math trap, bit 7 bad shift, bit 6 divide by zero
// - bit 5 set when a dma error trap occurs
// - global enable clear blocks user interrupts but not traps
// - capture select chooses latched or live vector number
// - trap vectors 0,1,2,3,4,6; 5 and 7 reserved
// - external input polarity bit 1 falling edge, 0 rising edge
//
// Chosen here: the Wishbone slave port and the address map.
module ipt_ctrl
    import ipt_pkg::*;
#(
    parameter int NUM_SRC = 16,
    parameter int NUM_EXT = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic [NUM_EXT-1:0] ext_irq_pin,
    input wire logic acc_a_ovf,
    input wire logic acc_b_ovf,
    input wire logic acc_a_cat,
    input wire logic acc_b_cat,
    input wire logic bad_shift,
    input wire logic divide_zero,
    input wire logic dma_error,
    input wire logic addr_error,
    input wire logic stack_error,
    input wire logic osc_fail,
    input wire logic hard_trap,
    input wire logic soft_trap,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic [3:0] irq_level,
    input wire logic irq_ack,
    input wire logic level_restore,
    input wire logic [3:0] restore_level,
    output logic [3:0] cpu_level,
    output logic var_latency,
    output logic alt_vector_table
);
    localparam int NPRIO = (NUM_SRC + 3) / 4;

    logic [2:0] ipl_reg;
    logic cpu_priority_top_bit_reg;
    logic var_reg;
    logic [15:0] ctl1_reg;
    logic [15:0] ctl2_reg;
    logic vector_capture_select_reg;
    logic [3:0] ilr_reg;
    logic [7:0] vec_latch_reg;
    logic [NUM_SRC-1:0] flag_reg;
    logic [NUM_SRC-1:0] en_reg;
    logic [NUM_SRC*3-1:0] prio_reg;
    logic [7:0] trap_pend_reg;
    logic irq_req_reg;
    logic [7:0] irq_vec_reg;
    logic [3:0] irq_lvl_reg;
    logic irq_trap_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [NUM_EXT-1:0] sync_a_reg;
    logic [NUM_EXT-1:0] sync_b_reg;
    logic [NUM_EXT-1:0] sync_c_reg;
    logic [NUM_EXT-1:0] ext_lvl_reg;

    ipt_arb_if #(.N(NUM_SRC)) arb_bus();

    ipt_arbiter #(.N(NUM_SRC)) u_arb (
        .bus(arb_bus)
    );

    // bus strobes
    logic req;
    logic wr;
    logic [15:0] wd;
    logic [1:0] wsel;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = ce && req && wb_we_i && ack_reg;
    assign wd = wb_dat_i[15:0];
    assign wsel = wb_sel_i[1:0];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // external pin synchronisers and edge select
    logic [NUM_EXT-1:0] ext_change;
    logic [NUM_EXT-1:0] ext_ev;
    logic [NUM_EXT-1:0] ext_pol;
    assign ext_pol = ctl2_reg[NUM_EXT-1:0];
    assign ext_change = ~(sync_b_reg ^ sync_c_reg) & (sync_c_reg ^ ext_lvl_reg);
    assign ext_ev = ext_change & (ext_pol ^ sync_c_reg);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
            sync_c_reg <= '0;
            ext_lvl_reg <= '0;
        end else if (ce) begin
            sync_a_reg <= ext_irq_pin;
            sync_b_reg <= sync_a_reg;
            sync_c_reg <= sync_b_reg;
            ext_lvl_reg <= ext_lvl_reg ^ ext_change;
        end
    end

    // trap events
    logic ova_ev;
    logic ovb_ev;
    logic cata_ev;
    logic catb_ev;
    logic math_ev;
    assign ova_ev = acc_a_ovf && ctl1_reg[C1_OVA_EN];
    assign ovb_ev = acc_b_ovf && ctl1_reg[C1_OVB_EN];
    assign cata_ev = acc_a_cat && ctl1_reg[C1_CAT_EN];
    assign catb_ev = acc_b_cat && ctl1_reg[C1_CAT_EN];
    assign math_ev = ova_ev || ovb_ev || cata_ev || catb_ev || bad_shift ||
                     divide_zero;

    logic [7:0] trap_set;
    always_comb begin
        trap_set = 8'h00;
        trap_set[TV_OSC] = osc_fail;
        trap_set[TV_ADDR] = addr_error;
        trap_set[TV_HARD] = hard_trap;
        trap_set[TV_STACK] = stack_error;
        trap_set[TV_MATH] = math_ev;
        trap_set[TV_SOFT] = soft_trap || dma_error;
    end

    // trap selection, lowest vector first
    logic trap_valid;
    logic [2:0] trap_vec;
    always_comb begin
        trap_valid = 1'b0;
        trap_vec = 3'h0;
        for (int v = 7; v >= 0; v--) begin
            if (trap_pend_reg[v]) begin
                trap_valid = 1'b1;
                trap_vec = 3'(v);
            end
        end
    end

    logic [3:0] trap_lvl;
    logic [3:0] cur_lvl;
    logic user_ok;
    logic trap_ok;
    logic take;
    assign trap_lvl = TRAP_TOP_LEVEL - {1'b0, trap_vec};
    assign cur_lvl = {cpu_priority_top_bit_reg, ipl_reg};
    assign arb_bus.pend = flag_reg & en_reg;
    assign arb_bus.prio = prio_reg;
    assign user_ok = arb_bus.valid && ctl2_reg[C2_GIE] &&
                     !cpu_priority_top_bit_reg &&
                     ipl_reg != IPL_USER_OFF &&
                     {1'b0, arb_bus.level} > cur_lvl;
    assign trap_ok = trap_valid && trap_lvl > cur_lvl;
    assign take = ce && irq_ack && irq_req_reg;

    logic [7:0] user_vec;
    logic [7:0] live_vec;
    assign user_vec = USER_VEC_BASE + 8'(arb_bus.idx);
    assign live_vec = trap_valid ? {5'h00, trap_vec} :
                      arb_bus.valid ? user_vec : 8'h00;

    // presentation to the core
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_req_reg <= 1'b0;
            irq_vec_reg <= 8'h00;
            irq_lvl_reg <= 4'h0;
            irq_trap_reg <= 1'b0;
        end else if (ce) begin
            irq_req_reg <= (trap_ok || user_ok) && !take;
            irq_trap_reg <= trap_ok;
            irq_vec_reg <= trap_ok ? {5'h00, trap_vec} : user_vec;
            irq_lvl_reg <= trap_ok ? trap_lvl : {1'b0, arb_bus.level};
        end
    end
    assign irq_req = irq_req_reg;
    assign irq_vector = irq_vec_reg;
    assign irq_level = irq_lvl_reg;
    assign cpu_level = cur_lvl;
    assign var_latency = var_reg;
    assign alt_vector_table = ctl2_reg[C2_AIVT];

    // cpu priority level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ipl_reg <= IPL_RST;
            cpu_priority_top_bit_reg <= 1'b0;
        end else if (ce) begin
            if (take) begin
                cpu_priority_top_bit_reg <= irq_lvl_reg[3];
                ipl_reg <= (!irq_trap_reg && ctl1_reg[C1_NEST]) ?
                           IPL_USER_OFF : irq_lvl_reg[2:0];
            end else if (level_restore) begin
                {cpu_priority_top_bit_reg, ipl_reg} <= restore_level;
            end else if (wr && wb_adr_i == OFS_STATUS && wsel[0] &&
                         !ctl1_reg[C1_NEST]) begin
                ipl_reg <= wd[STAT_IPL_LSB +: 3];
            end
        end
    end

    // vector status latch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ilr_reg <= 4'h0;
            vec_latch_reg <= 8'h00;
            vector_capture_select_reg <= 1'b0;
        end else if (ce) begin
            if (take) begin
                ilr_reg <= irq_lvl_reg;
                vec_latch_reg <= irq_vec_reg;
            end
            if (wr && wb_adr_i == OFS_VSTAT && wsel[1]) begin
                vector_capture_select_reg <= wd[VS_HOLD];
            end
        end
    end

    // trap pending, set wins over acknowledge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trap_pend_reg <= 8'h00;
        end else if (ce) begin
            trap_pend_reg <= (trap_pend_reg &
                             ~((take && irq_trap_reg) ?
                               (8'h01 << irq_vec_reg[2:0]) : 8'h00)) |
                             trap_set;
        end
    end

    // core control and trap control registers
    logic [15:0] c1_set;
    always_comb begin
        c1_set = 16'h0000;
        c1_set[C1_OVA_FLAG] = ova_ev;
        c1_set[C1_OVB_FLAG] = ovb_ev;
        c1_set[C1_CATA_FLAG] = cata_ev;
        c1_set[C1_CATB_FLAG] = catb_ev;
        c1_set[C1_SHIFT] = bad_shift;
        c1_set[C1_DIV0] = divide_zero;
        c1_set[C1_MATH] = math_ev;
        c1_set[C1_DMA] = dma_error;
        c1_set[C1_ADDR] = addr_error;
        c1_set[C1_STACK] = stack_error;
        c1_set[C1_OSC] = osc_fail;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl1_reg <= C1_RST;
            ctl2_reg <= C2_RST;
            var_reg <= 1'b0;
        end else if (ce) begin
            if (wr && wb_adr_i == OFS_CTL1) begin
                ctl1_reg <= (wmerge(ctl1_reg, wd, wsel) & C1_MASK) | c1_set;
            end else begin
                ctl1_reg <= ctl1_reg | c1_set;
            end
            if (wr && wb_adr_i == OFS_CTL2) begin
                ctl2_reg <= wmerge(ctl2_reg, wd, wsel) & C2_MASK;
            end
            if (wr && wb_adr_i == OFS_CORE && wsel[1]) begin
                var_reg <= wd[CORE_VAR_BIT];
            end
        end
    end

    // source flags, enables and priorities
    logic [NUM_SRC-1:0] src_set;
    logic [15:0] flag_wm;
    logic [15:0] en_wm;
    assign flag_wm = wmerge(16'(flag_reg), wd, wsel);
    assign en_wm = wmerge(16'(en_reg), wd, wsel);
    always_comb begin
        src_set = src_event;
        src_set[NUM_EXT-1:0] = src_event[NUM_EXT-1:0] | ext_ev;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_reg <= '0;
        end else if (ce) begin
            if (wr && wb_adr_i == OFS_FLAG) begin
                flag_reg <= flag_wm[NUM_SRC-1:0] | src_set;
            end else begin
                flag_reg <= flag_reg | src_set;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_reg <= '0;
        end else if (ce && wr && wb_adr_i == OFS_ENABLE) begin
            en_reg <= en_wm[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prio_reg <= '0;
        end else if (ce && wr) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                if (wb_adr_i == 8'(OFS_PRIO + 4 * (s / 4)) &&
                    wsel[(s % 4) / 2]) begin
                    prio_reg[s*3 +: 3] <= wd[(s%4)*4 +: 3];
                end
            end
        end
    end

    // read mux
    logic [31:0] rdata;
    logic [7:0] prio_off;
    assign prio_off = wb_adr_i - OFS_PRIO;
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFS_STATUS: rdata[STAT_IPL_LSB +: 3] = ipl_reg;
            OFS_CORE: begin
                rdata[CORE_VAR_BIT] = var_reg;
                rdata[CORE_CPU_PRIORITY_TOP_BIT_BIT] = cpu_priority_top_bit_reg;
            end
            OFS_CTL1: rdata[15:0] = ctl1_reg;
            OFS_CTL2: rdata[15:0] = ctl2_reg;
            OFS_VSTAT: begin
                rdata[VS_HOLD] = vector_capture_select_reg;
                rdata[VS_ILR_LSB +: 4] = ilr_reg;
                rdata[7:0] = vector_capture_select_reg ? live_vec : vec_latch_reg;
            end
            OFS_FLAG: rdata[NUM_SRC-1:0] = flag_reg;
            OFS_ENABLE: rdata[NUM_SRC-1:0] = en_reg;
            default: begin
                if (wb_adr_i >= OFS_PRIO && prio_off[7:2] < 6'(NPRIO)) begin
                    for (int k = 0; k < 4; k++) begin
                        if (int'(prio_off[7:2]) * 4 + k < NUM_SRC) begin
                            rdata[k*4 +: 3] =
                                prio_reg[(int'(prio_off[7:2]) * 4 + k) * 3 +: 3];
                        end
                    end
                end
            end
        endcase
    end

    // wishbone answer one cycle after the request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                dat_reg <= rdata;
            end
        end
    end

    // checks
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        !(wr && wb_adr_i == OFS_FLAG) |=>
        (flag_reg & $past(flag_reg)) == $past(flag_reg))
        else $error("request flag dropped without a write");
    chk_enable_gate: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req_reg) && !irq_trap_reg |->
        $past(arb_bus.pend[arb_bus.idx]))
        else $error("disabled source presented");
    chk_top_blocks: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req_reg) && !irq_trap_reg |->
        $past(!cpu_priority_top_bit_reg && ctl2_reg[C2_GIE]))
        else $error("user interrupt under top level or global off");
    chk_level_seven: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req_reg) && !irq_trap_reg |->
        $past(ipl_reg) != IPL_USER_OFF)
        else $error("user interrupt at level seven");
    chk_nest_ro: assert property (@(posedge mclk) disable iff (rst)
        ctl1_reg[C1_NEST] && !take && !(ce && level_restore) |=>
        $stable(ipl_reg))
        else $error("level changed while nesting disabled");
    chk_ack_latch: assert property (@(posedge mclk) disable iff (rst)
        take |=> ilr_reg == $past(irq_lvl_reg) &&
        vec_latch_reg == $past(irq_vec_reg))
        else $error("vector status not latched at acknowledge");
    chk_nest_reset: assert property (@(posedge mclk)
        rst |=> !ctl1_reg[C1_NEST])
        else $error("nesting disable not clear after reset");
    chk_ova_gate: assert property (@(posedge mclk) disable iff (rst)
        ce && !ctl1_reg[C1_OVA_EN] && !(wr && wb_adr_i == OFS_CTL1) |=>
        !$rose(ctl1_reg[C1_OVA_FLAG]))
        else $error("overflow cause set while trap disabled");
    chk_user_prio: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req_reg) && !irq_trap_reg |->
        irq_lvl_reg > $past(cur_lvl))
        else $error("user priority not above cpu level");
endmodule

// ---- core/ipt_pkg.sv ----
// constants for the interrupt priority and trap control block
package ipt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CORE = 8'h04;
    localparam logic [7:0] OFS_CTL1 = 8'h08;
    localparam logic [7:0] OFS_CTL2 = 8'h0c;
    localparam logic [7:0] OFS_VSTAT = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    localparam logic [7:0] OFS_ENABLE = 8'h18;
    localparam logic [7:0] OFS_PRIO = 8'h20;
    // field positions
    localparam int STAT_IPL_LSB = 5;
    localparam int CORE_VAR_BIT = 15;
    localparam int CORE_CPU_PRIORITY_TOP_BIT_BIT = 3;
    localparam int C1_NEST = 15;
    localparam int C1_OVA_FLAG = 14;
    localparam int C1_OVB_FLAG = 13;
    localparam int C1_CATA_FLAG = 12;
    localparam int C1_CATB_FLAG = 11;
    localparam int C1_OVA_EN = 10;
    localparam int C1_OVB_EN = 9;
    localparam int C1_CAT_EN = 8;
    localparam int C1_SHIFT = 7;
    localparam int C1_DIV0 = 6;
    localparam int C1_DMA = 5;
    localparam int C1_MATH = 4;
    localparam int C1_ADDR = 3;
    localparam int C1_STACK = 2;
    localparam int C1_OSC = 1;
    localparam int C2_GIE = 15;
    localparam int C2_AIVT = 8;
    localparam int VS_HOLD = 13;
    localparam int VS_ILR_LSB = 8;
    // reset values and writable masks
    localparam logic [15:0] C1_RST = 16'h0000;
    localparam logic [15:0] C1_MASK = 16'hfffe;
    localparam logic [15:0] C2_RST = 16'h8000;
    localparam logic [15:0] C2_MASK = 16'h810f;
    localparam logic [2:0] IPL_RST = 3'h0;
    localparam logic [2:0] IPL_USER_OFF = 3'h7;
    localparam logic [3:0] TRAP_TOP_LEVEL = 4'hf;
    // trap vectors
    localparam logic [2:0] TV_OSC = 3'h0;
    localparam logic [2:0] TV_ADDR = 3'h1;
    localparam logic [2:0] TV_HARD = 3'h2;
    localparam logic [2:0] TV_STACK = 3'h3;
    localparam logic [2:0] TV_MATH = 3'h4;
    localparam logic [2:0] TV_SOFT = 3'h6;
    localparam logic [7:0] USER_VEC_BASE = 8'h08;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] wmerge(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0] sel);
        wmerge = {sel[1] ? wd[15:8] : old[15:8],
                  sel[0] ? wd[7:0] : old[7:0]};
    endfunction
endpackage

// ---- dv/interrupt_priority_trap_control_tb.sv ----
// self-checking bench for the interrupt priority and trap block
module interrupt_priority_trap_control_tb import ipt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] src = 16'h0;
    logic [11:0] trp = 12'h0;
    logic ireq;
    logic [7:0] ivec;
    logic [3:0] ilvl;
    logic iack;
    logic lrest = 1'b0;
    logic [3:0] rlvl = 4'h0;
    logic [3:0] lvl;
    logic varl;
    logic men = 1'b0;
    logic [3:0] mdly = 4'h3;
    logic [7:0] gvec;
    logic [3:0] glvl;
    logic [7:0] ntk;
    logic [15:0] q;
    logic [3:0] ext = 4'h0;
    logic avt;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [2:0] tv [12] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h6,
                            3'h1, 3'h3, 3'h0, 3'h2, 3'h6};
    logic [15:0] cf [12] = '{16'h4710, 16'h2710, 16'h1710, 16'h0f10,
                             16'h0790, 16'h0750, 16'h0720, 16'h0708,
                             16'h0704, 16'h0702, 16'h0700, 16'h0700};

    ipt_ctrl u_dut (
        .mclk(mclk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .src_event(src),
        .ext_irq_pin(ext), .acc_a_ovf(trp[0]), .acc_b_ovf(trp[1]),
        .acc_a_cat(trp[2]), .acc_b_cat(trp[3]), .bad_shift(trp[4]),
        .divide_zero(trp[5]), .dma_error(trp[6]), .addr_error(trp[7]),
        .stack_error(trp[8]), .osc_fail(trp[9]), .hard_trap(trp[10]),
        .soft_trap(trp[11]), .irq_req(ireq), .irq_vector(ivec),
        .irq_level(ilvl), .irq_ack(iack), .level_restore(lrest),
        .restore_level(rlvl), .cpu_level(lvl), .var_latency(varl),
        .alt_vector_table(avt)
    );
    ipt_core_model u_core (
        .mclk(mclk), .rst(rst), .en(men), .dly(mdly), .irq_req(ireq),
        .irq_vector(ivec), .irq_level(ilvl), .irq_ack(iack),
        .got_vec(gvec), .got_lvl(glvl), .n_taken(ntk)
    );

    always #2 mclk = ~mclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic ev(input logic [15:0] s, input logic [11:0] t);
        @(posedge mclk);
        src <= s;
        trp <= t;
        @(posedge mclk);
        src <= 16'h0;
        trp <= 12'h0;
    endtask
    task automatic restore(input logic [3:0] l);
        @(posedge mclk);
        lrest <= 1'b1;
        rlvl <= l;
        @(posedge mclk);
        lrest <= 1'b0;
    endtask
    task automatic take();
        logic [7:0] k;
        int n;
        k = ntk;
        n = 0;
        while (ntk === k && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk(16'(ntk), 16'(k + 8'h01));
        tick(1);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        xfer(0, OFS_CTL2, 0);
        chk(q, C2_RST);
        xfer(0, OFS_CTL1, 0);
        chk(q, C1_RST);
        xfer(1, OFS_CTL1, 16'hffff);
        xfer(0, OFS_CTL1, 0);
        chk(q, 16'hfffe);
        xfer(1, OFS_CORE, 16'hffff);
        xfer(0, OFS_CORE, 0);
        chk(q, 16'h8000);
        chk(16'(varl), 16'h0001);
        xfer(1, OFS_CORE, 0);
        xfer(1, OFS_CTL1, 0);
        $display("test registers done");
        xfer(1, OFS_STATUS, 16'h00e0);
        tick(1);
        chk(16'(lvl), 16'h0007);
        xfer(1, OFS_PRIO, 16'h7553);
        xfer(1, OFS_ENABLE, 16'h0007);
        ev(16'h000f, 0);
        tick(4);
        chk(16'(ireq), 16'h0000);
        xfer(1, OFS_STATUS, 0);
        tick(3);
        chk(16'(ivec), 16'h0009);
        chk(16'(ilvl), 16'h0005);
        men <= 1'b1;
        take();
        chk(16'(gvec), 16'h0009);
        chk(16'(lvl), 16'h0005);
        xfer(0, OFS_VSTAT, 0);
        chk(q, 16'h0509);
        xfer(0, OFS_FLAG, 0);
        chk(q, 16'h000f);
        xfer(1, OFS_FLAG, 16'h0001);
        xfer(0, OFS_FLAG, 0);
        chk(q, 16'h0001);
        xfer(1, OFS_VSTAT, 16'h2000);
        xfer(0, OFS_VSTAT, 0);
        chk(q, 16'h2508);
        xfer(1, OFS_VSTAT, 0);
        $display("test user priority done");
        xfer(1, OFS_CTL1, 16'h8000);
        mdly <= 4'h0;
        restore(0);
        take();
        chk(16'(gvec), 16'h0008);
        chk(16'(lvl), 16'h0007);
        xfer(1, OFS_STATUS, 0);
        tick(1);
        chk(16'(lvl), 16'h0007);
        xfer(1, OFS_CTL1, 0);
        xfer(1, OFS_CTL2, 0);
        restore(0);
        tick(4);
        chk(16'(ireq), 16'h0000);
        $display("test nesting done");
        for (int i = 0; i < 12; i++) begin
            restore(0);
            xfer(1, OFS_CTL1, 16'h0700);
            ev(0, 12'(1 << i));
            take();
            chk(16'(gvec), 16'(tv[i]));
            chk(16'(glvl), 16'(4'hf - {1'b0, tv[i]}));
            xfer(0, OFS_CTL1, 0);
            chk(q, cf[i]);
        end
        chk(16'(lvl[3]), 16'h0001);
        xfer(1, OFS_CORE, 0);
        xfer(0, OFS_CORE, 0);
        chk(q, 16'h0008);
        xfer(1, OFS_CTL1, 0);
        ev(0, 12'h001);
        tick(4);
        chk(16'(ireq), 16'h0000);
        xfer(1, OFS_CTL2, C2_RST);
        tick(4);
        chk(16'(ireq), 16'h0000);
        restore(0);
        take();
        chk(16'(gvec), 16'h0008);
        $display("test traps done");
        xfer(1, OFS_ENABLE, 16'h0000);
        xfer(1, OFS_FLAG, 16'h0000);
        xfer(1, OFS_CTL2, 16'h8104);
        ext <= 4'h6;
        tick(8);
        chk(16'(avt), 16'h0001);
        xfer(0, OFS_FLAG, 0);
        chk(q, 16'h0002);
        ext <= 4'h0;
        tick(8);
        xfer(0, OFS_FLAG, 0);
        chk(q, 16'h0006);
        $display("test ext pins done");
        print_verdict();
    end
endmodule

// ---- dv/ipt_core_model.sv ----
// cpu core model that takes presented vectors after a set delay
module ipt_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic en,
    input wire logic [3:0] dly,
    input wire logic irq_req,
    input wire logic [7:0] irq_vector,
    input wire logic [3:0] irq_level,
    output logic irq_ack,
    output logic [7:0] got_vec,
    output logic [3:0] got_lvl,
    output logic [7:0] n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // ack pulse, vector and level taken at the edge it is seen
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
            cnt <= 4'h0;
            got_vec <= 8'h00;
            got_lvl <= 4'h0;
            n_taken <= 8'h00;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            cnt <= 4'h0;
            if (irq_req) begin
                got_vec <= irq_vector;
                got_lvl <= irq_level;
                n_taken <= n_taken + 8'h01;
            end
        end else if (en && irq_req) begin
            if (cnt == dly) begin
                irq_ack <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end else begin
            cnt <= 4'h0;
        end
    end
endmodule
